// ===== esp_top.sv
// Enhanced serial port core with APB register slave
// Contract
// [R01] Shift mode: data on receive pin, clock on transmit pin, eight bits LSB first.
// [R02] Shift mode bit rate is CPU clock over sixteen.
// [R03] 8-bit frame: low start, eight data bits LSB first, high stop.
// [R04] 8-bit frame: received stop bit lands in rx_ninth_bit.
// [R05] Variable modes take rate from Timer 1 overflow or dedicated generator.
// [R06] 9-bit frames: eleven bits, ninth from tx_ninth_bit, received ninth kept, stop dropped.
// [R07] Fixed 9-bit mode runs at CPU clock over 16 or 32 by rate_double_sel.
// [R08] Dedicated generator uses 16-bit divisor from two byte registers.
// [R09] Timer 1 rate is halved again when rate_double_sel is zero.
// [R10] Framing error in status; frame_err_view_sel shows it in control bit 7.
// [R11] Software sets mode bits while frame_err_view_sel is zero.
// [R12] Eleven consecutive low bit times flag a break in status.
// [R13] A break may reset the device and force programming mode.
// [R14] Double buffering accepts next character mid-frame; follows after one stop bit.
// [R15] tx_double_buffer_en zero gives single buffered transmit.
// [R16] Software keeps double buffering off in shift mode.
// [R17] Double buffered: tx_irq_flag rises when holding buffer frees.
// [R18] Single buffered: software holds tx_ninth_bit until transmit flag.
// [R19] Double buffered: ninth bit latched into holding buffer with the byte.
// [R20] No Timer 2 rate source exists.
// [R21] rx_irq_flag after complete stored character; bits sampled mid-period.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module esp_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer1_ovf,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  output logic break_reset,
  output logic isp_force
);
  typedef struct packed {
    logic mode_hi;
    logic mode_lo;
    logic rx_en;
    logic tx_nb;
    logic rx_nb;
    logic tx_irq_flag;
    logic rx_irq_flag;
    logic [7:0] rx_buf;
    logic fe;
    logic brk;
    logic tx_double_buffer_en;
    logic brg_sel;
    logic brk_rst_en;
    logic rate_double_sel;
    logic frame_err_view_sel;
    logic [15:0] div;
    logic [7:0] hold;
    logic hold_nb;
    logic hold_v;
    esp_pkg::esp_tx_e tx_st;
    logic m0_rx;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_ph;
    esp_pkg::esp_rx_e rx_st;
    logic [9:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [3:0] rx_ph;
    logic s1;
    logic s2;
    logic s3;
    logic filt;
    logic [7:0] brk_cnt;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    logic brk_rst;
    logic isp;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } esp_top_s;
  esp_top_s st;
  esp_top_s next_st;
  logic os_tick;

  esp_baud u_baud (
    .core_clk(core_clk),
    .reset(reset),
    .mode({st.mode_hi, st.mode_lo}),
    .rate_double_sel(st.rate_double_sel),
    .brg_sel(st.brg_sel),
    .timer1_ovf(timer1_ovf),
    .baud_div(st.div),
    .os_tick(os_tick)
  );

  always_comb
  begin
    logic wr;
    logic setup;
    logic shift_mode;
    logic nine;
    logic [9:0] rsh;
    logic load_tx;
    logic [7:0] ld_data;
    logic ld_nb;
    wr = 1'b0;
    setup = 1'b0;
    shift_mode = 1'b0;
    nine = 1'b0;
    rsh = '0;
    load_tx = 1'b0;
    ld_data = '0;
    ld_nb = 1'b0;
    next_st = st;
    wr = psel & penable & st.pready & pwrite;
    setup = psel & ~penable;
    shift_mode = ({st.mode_hi, st.mode_lo} == esp_pkg::ESP_MODE_SHIFT);
    nine = st.mode_hi;
    next_st.brk_rst = 1'b0;
    // Input pin: a change counts once stages two and three agree
    next_st.s1 = rxd_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
      next_st.filt = st.s3;

    // APB slave, zero wait, read data prepared in the setup cycle
    next_st.pready = setup;
    next_st.pslverr = 1'b0;
    if (setup)
    begin
      next_st.prdata = '0;
      case (paddr)
        esp_pkg::ADDR_CTRL:
        begin
          next_st.prdata[7:0] = {st.frame_err_view_sel ? st.fe : st.mode_hi, st.mode_lo, 1'b0, st.rx_en, // [R10]
            st.tx_nb, st.rx_nb, st.tx_irq_flag, st.rx_irq_flag};
        end
        esp_pkg::ADDR_DATA: next_st.prdata[7:0] = st.rx_buf;
        esp_pkg::ADDR_STAT:
        begin
          next_st.prdata[esp_pkg::STAT_DBUF_EN] = st.tx_double_buffer_en;
          next_st.prdata[esp_pkg::STAT_BRG_SEL] = st.brg_sel;
          next_st.prdata[esp_pkg::STAT_BRK_RST] = st.brk_rst_en;
          next_st.prdata[esp_pkg::STAT_FE] = st.fe; // [R10]
          next_st.prdata[esp_pkg::STAT_BRK] = st.brk; // [R12]
          next_st.prdata[esp_pkg::STAT_HOLD] = st.hold_v;
          next_st.prdata[esp_pkg::STAT_BUSY] = (st.tx_st == esp_pkg::ESP_TX_BUSY);
        end
        esp_pkg::ADDR_PWR:
        begin
          next_st.prdata[esp_pkg::PWR_RATE_DBL] = st.rate_double_sel;
          next_st.prdata[esp_pkg::PWR_FE_VIEW] = st.frame_err_view_sel;
        end
        esp_pkg::ADDR_DIVL: next_st.prdata[7:0] = st.div[7:0];
        esp_pkg::ADDR_DIVH: next_st.prdata[7:0] = st.div[15:8];
        default: next_st.pslverr = 1'b1;
      endcase
    end

    // Register writes; hardware sets below override same-cycle clears
    if (wr)
    begin
      case (paddr)
        esp_pkg::ADDR_CTRL:
        begin
          // Bit 7 reaches the mode field only with the error view off [R10]
          if (st.frame_err_view_sel)
            next_st.fe = st.fe & pwdata[esp_pkg::CTRL_MODE_HI];
          else
            next_st.mode_hi = pwdata[esp_pkg::CTRL_MODE_HI];
          next_st.mode_lo = pwdata[esp_pkg::CTRL_MODE_LO];
          next_st.rx_en = pwdata[esp_pkg::CTRL_RX_EN];
          next_st.tx_nb = pwdata[esp_pkg::CTRL_TX_NB];
          next_st.rx_nb = pwdata[esp_pkg::CTRL_RX_NB];
          next_st.tx_irq_flag = pwdata[esp_pkg::CTRL_TX_IRQ];
          next_st.rx_irq_flag = pwdata[esp_pkg::CTRL_RX_IRQ];
        end
        esp_pkg::ADDR_DATA:
        begin
          if (st.tx_double_buffer_en && !shift_mode)
          begin
            // Ninth bit travels with the byte into the holding slot [R19]
            if (!st.hold_v)
            begin
              next_st.hold = pwdata[7:0]; // [R14]
              next_st.hold_nb = st.tx_nb; // [R19]
              next_st.hold_v = 1'b1;
            end
          end
          else if (st.tx_st == esp_pkg::ESP_TX_IDLE)
          begin
            load_tx = 1'b1; // [R15]
            ld_data = pwdata[7:0];
            ld_nb = st.tx_nb;
          end
        end
        esp_pkg::ADDR_STAT:
        begin
          next_st.tx_double_buffer_en = pwdata[esp_pkg::STAT_DBUF_EN];
          next_st.brg_sel = pwdata[esp_pkg::STAT_BRG_SEL];
          next_st.brk_rst_en = pwdata[esp_pkg::STAT_BRK_RST];
          next_st.fe = st.fe & pwdata[esp_pkg::STAT_FE];
          next_st.brk = st.brk & pwdata[esp_pkg::STAT_BRK];
        end
        esp_pkg::ADDR_PWR:
        begin
          next_st.rate_double_sel = pwdata[esp_pkg::PWR_RATE_DBL];
          next_st.frame_err_view_sel = pwdata[esp_pkg::PWR_FE_VIEW];
        end
        esp_pkg::ADDR_DIVL: next_st.div[7:0] = pwdata[7:0]; // [R08]
        esp_pkg::ADDR_DIVH: next_st.div[15:8] = pwdata[7:0]; // [R08]
        default: next_st.div = st.div;
      endcase
    end

    // Holding slot feeds an idle shifter, freeing the slot at once
    if (!load_tx && st.hold_v && st.tx_st == esp_pkg::ESP_TX_IDLE && !shift_mode)
    begin
      load_tx = 1'b1;
      ld_data = st.hold;
      ld_nb = st.hold_nb;
      next_st.hold_v = 1'b0;
      next_st.tx_irq_flag = 1'b1; // [R17]
    end

    // Transmitter and shift-mode engine
    case (st.tx_st)
      esp_pkg::ESP_TX_IDLE:
      begin
        next_st.txd = 1'b1;
        next_st.rxd_oe = 1'b0;
        next_st.tx_ph = '0;
        if (load_tx)
        begin
          next_st.tx_st = esp_pkg::ESP_TX_BUSY;
          next_st.m0_rx = 1'b0;
          if (shift_mode)
          begin
            next_st.tx_sh = {3'h0, ld_data}; // [R01]
            next_st.tx_cnt = esp_pkg::BITS_SHIFT;
          end
          else
          begin
            next_st.tx_sh = {1'b1, nine ? ld_nb : 1'b1, ld_data, 1'b0}; // [R03] [R06]
            next_st.tx_cnt = nine ? esp_pkg::BITS_F9 : esp_pkg::BITS_F8; // [R06]
          end
        end
        else if (shift_mode && st.rx_en && !st.rx_irq_flag)
        begin
          next_st.tx_st = esp_pkg::ESP_TX_BUSY;
          next_st.m0_rx = 1'b1;
          next_st.tx_cnt = esp_pkg::BITS_SHIFT;
        end
      end
      esp_pkg::ESP_TX_BUSY:
      begin
        if (shift_mode)
        begin
          next_st.txd = st.tx_ph[3]; // [R01]
          next_st.rxd_oe = ~st.m0_rx;
          next_st.rxd_out = st.tx_sh[0];
        end
        else
        begin
          next_st.txd = st.tx_sh[0];
          next_st.rxd_oe = 1'b0;
        end
        if (os_tick)
        begin
          next_st.tx_ph = st.tx_ph + 4'h1;
          if (st.tx_ph == esp_pkg::PH_LAST)
          begin
            // Shift receive samples late in the bit, after the clock rises
            if (shift_mode && st.m0_rx)
              next_st.rx_sh = {st.filt, st.rx_sh[9:1]}; // [R01]
            next_st.tx_sh = {1'b1, st.tx_sh[10:1]};
            next_st.tx_cnt = st.tx_cnt - 4'h1;
            if (st.tx_cnt == 4'h1)
            begin
              next_st.tx_st = esp_pkg::ESP_TX_IDLE;
              if (shift_mode && st.m0_rx)
              begin
                next_st.rx_buf = {st.filt, st.rx_sh[9:3]};
                next_st.rx_irq_flag = 1'b1; // [R21]
              end
              else if (!(st.tx_double_buffer_en && !shift_mode))
                next_st.tx_irq_flag = 1'b1; // [R15]
            end
          end
        end
      end
      default: next_st.tx_st = esp_pkg::ESP_TX_IDLE;
    endcase

    // Frame receiver, sampling at mid bit
    if (shift_mode || !st.rx_en)
      next_st.rx_st = esp_pkg::ESP_RX_IDLE;
    else
    begin
      case (st.rx_st)
        esp_pkg::ESP_RX_IDLE:
        begin
          next_st.rx_ph = '0;
          if (!st.filt)
            next_st.rx_st = esp_pkg::ESP_RX_START;
        end
        esp_pkg::ESP_RX_START:
        begin
          if (os_tick)
          begin
            next_st.rx_ph = st.rx_ph + 4'h1;
            if (st.rx_ph == esp_pkg::PH_MID) // [R21]
            begin
              next_st.rx_ph = '0;
              next_st.rx_cnt = nine ? esp_pkg::RX_N9 : esp_pkg::RX_N8;
              next_st.rx_st = st.filt ? esp_pkg::ESP_RX_IDLE : esp_pkg::ESP_RX_BITS;
            end
          end
        end
        esp_pkg::ESP_RX_BITS:
        begin
          if (os_tick)
          begin
            next_st.rx_ph = st.rx_ph + 4'h1;
            if (st.rx_ph == esp_pkg::PH_LAST)
            begin
              rsh = {st.filt, st.rx_sh[9:1]};
              next_st.rx_sh = rsh;
              next_st.rx_cnt = st.rx_cnt - 4'h1;
              if (st.rx_cnt == 4'h1)
              begin
                next_st.rx_st = esp_pkg::ESP_RX_IDLE;
                next_st.rx_buf = nine ? rsh[7:0] : rsh[8:1];
                next_st.rx_nb = nine ? rsh[8] : rsh[9]; // [R04] [R06]
                if (!rsh[9])
                  next_st.fe = 1'b1; // [R10]
                next_st.rx_irq_flag = 1'b1; // [R21]
              end
            end
          end
        end
        default: next_st.rx_st = esp_pkg::ESP_RX_IDLE;
      endcase
    end

    // Break: eleven bit times of low line
    if (os_tick)
    begin
      if (st.filt)
        next_st.brk_cnt = '0;
      else if (st.brk_cnt != esp_pkg::BRK_TICKS)
      begin
        next_st.brk_cnt = st.brk_cnt + 8'h01;
        if (st.brk_cnt == esp_pkg::BRK_TICKS - 8'h01)
        begin
          next_st.brk = 1'b1; // [R12]
          if (st.brk_rst_en)
          begin
            next_st.brk_rst = 1'b1; // [R13]
            next_st.isp = 1'b1; // [R13]
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.txd <= 1'b1;
      st.filt <= 1'b1;
      st.s1 <= 1'b1;
      st.s2 <= 1'b1;
      st.s3 <= 1'b1;
      st.div <= esp_pkg::DIV_RESET;
    end
    else
      st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign rxd_out = st.rxd_out;
  assign rxd_oe = st.rxd_oe;
  assign txd = st.txd;
  assign break_reset = st.brk_rst;
  assign isp_force = st.isp;
endmodule
`default_nettype wire

// ===== esp_pkg.sv
// Shared constants and types for the enhanced serial port
package esp_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_PWR = 8'h0c;
  localparam logic [7:0] ADDR_DIVL = 8'h10;
  localparam logic [7:0] ADDR_DIVH = 8'h14;
  // Control register bit positions
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_RX_EN = 4;
  localparam int CTRL_TX_NB = 3;
  localparam int CTRL_RX_NB = 2;
  localparam int CTRL_TX_IRQ = 1;
  localparam int CTRL_RX_IRQ = 0;
  // Status register bit positions
  localparam int STAT_DBUF_EN = 7;
  localparam int STAT_BRG_SEL = 6;
  localparam int STAT_BRK_RST = 5;
  localparam int STAT_FE = 3;
  localparam int STAT_BRK = 2;
  localparam int STAT_HOLD = 1;
  localparam int STAT_BUSY = 0;
  // Power control register bit positions
  localparam int PWR_RATE_DBL = 7;
  localparam int PWR_FE_VIEW = 6;
  // Bit timing: phases and break length in oversample ticks, frame lengths in bits
  localparam logic [3:0] PH_LAST = 4'hf;
  localparam logic [3:0] PH_MID = 4'h7;
  localparam logic [3:0] BITS_SHIFT = 4'h8;
  localparam logic [3:0] BITS_F8 = 4'ha;
  localparam logic [3:0] BITS_F9 = 4'hb;
  localparam logic [3:0] RX_N8 = 4'h9;
  localparam logic [3:0] RX_N9 = 4'ha;
  localparam logic [7:0] BRK_TICKS = 8'hb0;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  typedef enum logic [1:0] {ESP_MODE_SHIFT, ESP_MODE_F8, ESP_MODE_F9_FIX, ESP_MODE_F9_VAR} esp_mode_e;
  typedef enum logic [0:0] {ESP_TX_IDLE, ESP_TX_BUSY} esp_tx_e;
  typedef enum logic [1:0] {ESP_RX_IDLE, ESP_RX_START, ESP_RX_BITS} esp_rx_e;
endpackage

// ===== esp_baud.sv
// Oversample tick generator: fixed CPU divider, timer overflow or 16-bit divisor
`timescale 1ns/1ps
`default_nettype none
module esp_baud (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] mode,
  input wire logic rate_double_sel,
  input wire logic brg_sel,
  input wire logic timer1_ovf,
  input wire logic [15:0] baud_div,
  output logic os_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic t1_half;
    logic clk_half;
    logic tick;
  } esp_baud_s;
  esp_baud_s st;
  esp_baud_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.clk_half = ~st.clk_half;
    case (esp_pkg::esp_mode_e'(mode))
      esp_pkg::ESP_MODE_SHIFT:
      begin
        next_st.tick = 1'b1; // [R02]
      end
      esp_pkg::ESP_MODE_F9_FIX:
      begin
        next_st.tick = rate_double_sel | st.clk_half; // [R07]
      end
      default:
      begin
        // No third timer source exists here [R20]
        if (brg_sel) // [R05]
        begin
          if (st.cnt >= baud_div) // [R08]
          begin
            next_st.cnt = esp_pkg::DIV_RESET;
            next_st.tick = 1'b1;
          end
          else
          begin
            next_st.cnt = st.cnt + 16'h0001;
          end
        end
        else if (timer1_ovf)
        begin
          next_st.t1_half = ~st.t1_half;
          next_st.tick = rate_double_sel | st.t1_half; // [R09]
        end
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign os_tick = st.tick;
endmodule
`default_nettype wire

// ===== esp_props.sv
// Port checker for the serial port core
`timescale 1ns/1ps
`default_nettype none
module esp_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic rxd_in,
  input wire logic rxd_oe,
  input wire logic txd,
  input wire logic break_reset,
  input wire logic isp_force
);
  logic [1:0] mode;
  logic dbl, view;
  logic [7:0] low_cnt;
  wire logic acc = psel && penable && pready;
  wire logic wr_c = acc && pwrite && paddr == esp_pkg::ADDR_CTRL;
  wire logic wr_p = acc && pwrite && paddr == esp_pkg::ADDR_PWR;
  // Mode shadow; high bit frozen while the view is on
  always_ff @(posedge core_clk)
    mode <= reset ? 2'h0 : wr_c ? {view ? mode[1] : pwdata[7], pwdata[6]} : mode;
  always_ff @(posedge core_clk)
    {dbl, view} <= reset ? 2'h0 : wr_p ? pwdata[7:6] : {dbl, view};
  // Raw pin, so slack is left for the synchroniser
  always_ff @(posedge core_clk)
    low_cnt <= (reset || rxd_in) ? 8'h00 : low_cnt + 8'(low_cnt != 8'hff);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_half_low; (!txd)[*8] ##1 txd; endsequence
  sequence s_bit_low; (!txd)[*8] ##1 (!txd)[*8]; endsequence
  property p_oe_shift; rxd_oe |-> mode == 2'h0; endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("pin driven outside shift mode");
  property p_shift_clk; mode == 2'h0 && $fell(txd) |-> s_half_low; endproperty
  a_shift_clk: assert property (p_shift_clk) else $error("shift clock low phase wrong");
  property p_start16; mode == 2'h2 && dbl && $fell(txd) |-> s_bit_low; endproperty
  a_start16: assert property (p_start16) else $error("low bit shorter than 16 clocks");
  property p_brk_low; break_reset |-> $past(low_cnt, 4) >= 8'ha0; endproperty
  a_brk_low: assert property (p_brk_low) else $error("break without long low line");
  property p_brk_isp; break_reset |-> isp_force; endproperty
  a_brk_isp: assert property (p_brk_isp) else $error("break did not force isp");
  property p_isp_hold; isp_force |=> isp_force; endproperty
  a_isp_hold: assert property (p_isp_hold) else $error("isp force dropped");
  property p_brk_pulse; break_reset |=> !break_reset; endproperty
  a_brk_pulse: assert property (p_brk_pulse) else $error("break reset longer than a cycle");
  property p_fe_view; acc && !pwrite && paddr == esp_pkg::ADDR_CTRL && !view |-> prdata[7] == mode[1]; endproperty
  a_fe_view: assert property (p_fe_view) else $error("control bit 7 not mode high");
endmodule
bind esp_top esp_props u_props (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .rxd_in(rxd_in),
  .rxd_oe(rxd_oe), .txd(txd), .break_reset(break_reset), .isp_force(isp_force));
`default_nettype wire

// ===== esp_peer.sv
// Remote serial transceiver model
`timescale 1ns/1ps
`default_nettype none
module esp_peer (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic rxd_line,
  output logic rxd_drv
);
  int waited;
  initial rxd_drv = 1'b1;
  // Bounded wait for a level on the transmit pin
  task automatic wt(input logic v, input int lim);
    waited = 0;
    while (txd !== v && waited < lim)
    begin
      @(posedge core_clk);
      waited++;
    end
  endtask
  // Line idles high, like a pulled-up pin
  task automatic send(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++)
      repeat (per) @(posedge core_clk) rxd_drv <= bits[i];
    @(posedge core_clk) rxd_drv <= 1'b1;
  endtask
  // Returns at mid last bit so a following start is not missed
  task automatic recv(output logic [10:0] bits, output int gap, input int n, input int per);
    bits = 'x;
    wt(1'b0, 4000);
    gap = waited;
    repeat (per / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = txd;
      if (i < n - 1)
        repeat (per) @(posedge core_clk);
    end
  endtask
  task automatic recv_shift(output logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      wt(1'b0, 400);
      wt(1'b1, 400);
      d[i] = (waited < 400) ? rxd_line : 1'bx;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb_enhanced_serial_port.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
module tb_enhanced_serial_port;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic timer1_ovf = 1'b0, ovf_on = 1'b0, brk_seen = 1'b0;
  logic [7:0] paddr = 8'h00, sb;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, rxd_out, rxd_oe, txd, break_reset, isp_force, peer_rxd, err_v;
  logic [10:0] fr;
  int gap, errors = 0, checks_done = 0;
  wire logic rxd_line = rxd_oe ? rxd_out : peer_rxd;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    timer1_ovf <= ovf_on && !timer1_ovf;
    if (break_reset === 1'b1)
      brk_seen <= 1'b1;
  end
  esp_top DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_ovf(timer1_ovf), .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
    .break_reset(break_reset), .isp_force(isp_force));
  esp_peer peer (.core_clk(core_clk), .txd(txd), .rxd_line(rxd_line), .rxd_drv(peer_rxd));
  function automatic logic [31:0] f9(input logic n9, input logic [7:0] d);
    return {21'h0, 1'b1, n9, d, 1'b0};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rv = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      errors++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    check(what, rv, exp);
  endtask
  // Busy and holding bits both clear
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, esp_pkg::ADDR_STAT, 8'h00);
      n++;
    end
    while (rv[1:0] !== 2'h0 && n < 400);
    if (rv[1:0] !== 2'h0)
    begin
      errors++;
      close_out();
    end
  endtask
  task automatic rxf(input int per);
    peer.recv(fr, gap, 11, per);
    if (gap >= 4000)
    begin
      errors++;
      close_out();
    end
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++)
      rdc("reset value", 8'(i * 4), 32'h0);
    apb(1'b0, 8'h18, 8'h00);
    check("unmapped", {31'h0, err_v}, 32'h1);
    wr(esp_pkg::ADDR_DATA, 8'ha5);
    peer.recv_shift(sb);
    check("shift byte", {24'h0, sb}, 32'ha5);
    idle();
    // Shift receive: peer bits line up with the 16-clock shift clock
    wr(esp_pkg::ADDR_CTRL, 8'h10);
    peer.send({3'h0, 8'h6c}, 8, 16);
    rdc("shift rx flag", esp_pkg::ADDR_CTRL, 32'h11);
    rdc("shift rx byte", esp_pkg::ADDR_DATA, 32'h6c);
    wr(esp_pkg::ADDR_PWR, 8'h80);
    wr(esp_pkg::ADDR_CTRL, 8'h88);
    fork
      rxf(16);
      wr(esp_pkg::ADDR_DATA, 8'h3c);
    join
    check("fixed fast", {21'h0, fr}, f9(1'b1, 8'h3c));
    idle();
    wr(esp_pkg::ADDR_PWR, 8'h00);
    wr(esp_pkg::ADDR_CTRL, 8'h80);
    fork
      rxf(32);
      wr(esp_pkg::ADDR_DATA, 8'hc3);
    join
    check("fixed slow", {21'h0, fr}, f9(1'b0, 8'hc3));
    idle();
    // Divisor 1: tick every 2 clocks, 32 per bit
    wr(esp_pkg::ADDR_STAT, 8'h40);
    wr(esp_pkg::ADDR_DIVL, 8'h01);
    rdc("div low", esp_pkg::ADDR_DIVL, 32'h1);
    wr(esp_pkg::ADDR_CTRL, 8'h50);
    peer.send({1'b1, 8'h5a, 1'b0}, 10, 32);
    rdc("ctrl rx", esp_pkg::ADDR_CTRL, 32'h55);
    rdc("rx byte", esp_pkg::ADDR_DATA, 32'h5a);
    wr(esp_pkg::ADDR_CTRL, 8'h50);
    peer.send({1'b0, 8'h0f, 1'b0}, 10, 32);
    rdc("stat fe", esp_pkg::ADDR_STAT, 32'h48);
    wr(esp_pkg::ADDR_PWR, 8'h40);
    rdc("ctrl fe view", esp_pkg::ADDR_CTRL, 32'hd1);
    wr(esp_pkg::ADDR_PWR, 8'h00);
    rdc("ctrl mode view", esp_pkg::ADDR_CTRL, 32'h51);
    // Overflow every 2nd clock, halved: 64 per bit
    ovf_on <= 1'b1;
    wr(esp_pkg::ADDR_STAT, 8'h00);
    wr(esp_pkg::ADDR_CTRL, 8'hc0);
    fork
      rxf(64);
      wr(esp_pkg::ADDR_DATA, 8'h96);
    join
    check("timer frame", {21'h0, fr}, f9(1'b0, 8'h96));
    idle();
    wr(esp_pkg::ADDR_PWR, 8'h80);
    wr(esp_pkg::ADDR_STAT, 8'h80);
    wr(esp_pkg::ADDR_CTRL, 8'h88);
    fork
      rxf(16);
      begin
        wr(esp_pkg::ADDR_DATA, 8'h11);
        rdc("slot free", esp_pkg::ADDR_CTRL, 32'h8a);
        wr(esp_pkg::ADDR_CTRL, 8'h80);
        wr(esp_pkg::ADDR_DATA, 8'h22);
        wr(esp_pkg::ADDR_DATA, 8'h33);
        rdc("slot full", esp_pkg::ADDR_CTRL, 32'h80);
      end
    join
    check("first", {21'h0, fr}, f9(1'b1, 8'h11));
    rxf(16);
    check("second", {21'h0, fr}, f9(1'b0, 8'h22));
    check("one stop", {31'h0, gap <= 12}, 32'h1);
    peer.wt(1'b0, 400);
    check("no third", peer.waited, 32'h190);
    idle();
    // Single buffered: write while busy is dropped; flag cleared first
    wr(esp_pkg::ADDR_STAT, 8'h00);
    wr(esp_pkg::ADDR_CTRL, 8'h80);
    fork
      rxf(16);
      begin
        wr(esp_pkg::ADDR_DATA, 8'h44);
        wr(esp_pkg::ADDR_DATA, 8'h55);
        rdc("flag mid frame", esp_pkg::ADDR_CTRL, 32'h80);
      end
    join
    check("single", {21'h0, fr}, f9(1'b0, 8'h44));
    peer.wt(1'b0, 400);
    check("no second", peer.waited, 32'h190);
    rdc("flag at end", esp_pkg::ADDR_CTRL, 32'h82);
    wr(esp_pkg::ADDR_STAT, 8'h20);
    peer.send(11'h000, 11, 20);
    check("break pulse", {31'h0, brk_seen}, 32'h1);
    check("isp forced", {31'h0, isp_force}, 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
